// ---- core/mts_trap_setup.sv ----
`timescale 1ns/1ps
module mts_trap_setup
    import mts_pkg::*;
#(
    parameter bit        TABLE_CTRL_PRESENT = 1'b0,
    parameter mts_base_e BASE_SET_OPTION    = MTS_BASE_INTEGER,
    parameter bit        MULDIV_OPTION      = 1'b1,
    parameter int        IRQ_ID_WIDTH       = 8
) (
    input  wire logic        REF_CLK_IN,
    input  wire logic        RSTN_IN,
    input  wire logic        CLK_EN_IN,
    input  wire mts_op_e     CSR_OP_IN,
    input  wire logic [11:0] CSR_ADDR_IN,
    input  wire logic [31:0] CSR_WDATA_IN,
    input  wire logic [31:0] TVEC_RESET_ADDR_IN,
    input  wire logic [31:0] IRQ_LINES_IN,
    input  wire logic        TRAP_IN,
    input  wire logic        TRAP_IS_IRQ_IN,
    input  wire logic        TRAP_IS_NMI_IN,
    input  wire logic [IRQ_ID_WIDTH-1:0] TRAP_ID_IN,
    output logic      [31:0] CSR_RDATA_OUT,
    output logic             CSR_RVALID_OUT,
    output logic             CSR_UNMAPPED_OUT,
    output logic      [31:0] IRQ_GATED_OUT,
    output logic      [31:0] HANDLER_ADDR_OUT,
    output logic             HANDLER_VALID_OUT
);

    // table alignment exponent: larger of 6 and two plus id width
    localparam int VTAB_N = (2 + IRQ_ID_WIDTH > VTAB_MIN_ALIGN_BITS) ?
                            (2 + IRQ_ID_WIDTH) : VTAB_MIN_ALIGN_BITS;
    localparam logic [31:0] VTAB_MASK = ~((32'h1 << VTAB_N) - 32'h1);

    // only these bits of the enable register hold state in basic mode
    localparam logic [31:0] IRQ_ENABLE_WRITABLE = IRQ_ENABLE_FAST_MASK |
        (32'h1 << EXTERNAL_IRQ_ENABLE) |
        (32'h1 << TIMER_IRQ_ENABLE) |
        (32'h1 << SOFTWARE_IRQ_ENABLE);

    localparam logic [1:0] TVEC_MODE_RESET = TABLE_CTRL_PRESENT ?
        TVEC_MODE_TABLE : TVEC_MODE_VECTORED;

    // fixed capability word, built from configuration only
    localparam logic [31:0] CAP_WORD =
        ({30'h0000_0000, NATIVE_WORD_LENGTH_32} << NATIVE_WORD_LENGTH_LSB) |
        (32'h1 << CAP_BIT_COMPRESSED) |
        (32'h1 << CAP_BIT_USER_MODE) |
        (32'h1 << CAP_BIT_NONSTANDARD) |
        ((BASE_SET_OPTION == MTS_BASE_INTEGER) ?
            (32'h1 << CAP_BIT_INTEGER_BASE) : ZERO_WORD) |
        ((BASE_SET_OPTION == MTS_BASE_EMBEDDED) ?
            (32'h1 << CAP_BIT_EMBEDDED_BASE) : ZERO_WORD) |
        (MULDIV_OPTION ? (32'h1 << CAP_BIT_MULDIV) : ZERO_WORD);

    mts_state_s st_r;
    mts_state_s st_nxt;

    // register read view, used for reads and for set/clear merging
    function automatic logic [31:0] read_view(
        input logic [11:0] addr,
        input mts_state_s  s
    );
        logic [31:0] v;
        v = ZERO_WORD;
        unique case (addr)
            ADDR_ISA_CAPABILITY: begin
                v = CAP_WORD;
            end
            ADDR_IRQ_ENABLE: begin
                v = TABLE_CTRL_PRESENT ? ZERO_WORD :
                    (s.irq_enable & IRQ_ENABLE_WRITABLE);
            end
            ADDR_TRAP_VECTOR_BASE: begin
                v = {s.tvec_base, TVEC_ZERO_FIELD, s.tvec_mode};
            end
            ADDR_VECTOR_TABLE: begin
                v = TABLE_CTRL_PRESENT ? (s.vtab & VTAB_MASK) : ZERO_WORD;
            end
            default: begin
                v = ZERO_WORD;
            end
        endcase
        return v;
    endfunction

    // is the address one this block answers for
    function automatic logic is_mapped(input logic [11:0] addr);
        logic m;
        m = (addr == ADDR_ISA_CAPABILITY) ||
            (addr == ADDR_IRQ_ENABLE) ||
            (addr == ADDR_TRAP_VECTOR_BASE) ||
            (TABLE_CTRL_PRESENT && (addr == ADDR_VECTOR_TABLE));
        return m;
    endfunction

    // value that a write, set or clear instruction proposes
    function automatic logic [31:0] apply_op(
        input mts_op_e     op,
        input logic [31:0] old,
        input logic [31:0] wdata
    );
        logic [31:0] r;
        r = old;
        unique case (op)
            MTS_OP_NONE:  r = old;
            MTS_OP_WRITE: r = wdata;
            MTS_OP_SET:   r = old | wdata;
            MTS_OP_CLEAR: r = old & ~wdata;
        endcase
        return r;
    endfunction

    logic [31:0] cur_view;
    logic [31:0] new_val;
    logic        access;
    logic        writes;
    logic [31:0] tvec_word;
    logic [31:0] entry_off;

    always_comb begin
        cur_view = read_view(CSR_ADDR_IN, st_r);
        new_val  = apply_op(CSR_OP_IN, cur_view, CSR_WDATA_IN);
        access   = (CSR_OP_IN != MTS_OP_NONE);
        writes   = access && is_mapped(CSR_ADDR_IN);
        tvec_word = {st_r.tvec_base, TVEC_ZERO_FIELD, ENTRY_BYTE_BITS};
        entry_off = {{(32 - IRQ_ID_WIDTH){1'b0}}, TRAP_ID_IN} << ENTRY_SHIFT;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid        = 1'b0;
        st_nxt.handler_valid = 1'b0;

        // base taken from the port on the first enabled edge after reset,
        // since an async reset may only load constants
        if (st_r.boot) begin
            st_nxt.boot      = 1'b0;
            st_nxt.tvec_base =
                TVEC_RESET_ADDR_IN[31:TVEC_BASE_LSB];
        end

        if (access) begin
            st_nxt.rvalid   = 1'b1;
            st_nxt.rdata    = is_mapped(CSR_ADDR_IN) ? cur_view : ZERO_WORD;
            st_nxt.unmapped = ~is_mapped(CSR_ADDR_IN);
        end

        // a software write in the boot cycle wins over the port capture
        if (writes) begin
            unique case (CSR_ADDR_IN)
                ADDR_ISA_CAPABILITY: begin
                    st_nxt.irq_enable = st_r.irq_enable;
                end
                ADDR_IRQ_ENABLE: begin
                    if (!TABLE_CTRL_PRESENT) begin
                        st_nxt.irq_enable =
                            new_val & IRQ_ENABLE_WRITABLE;
                    end
                end
                ADDR_TRAP_VECTOR_BASE: begin
                    st_nxt.tvec_base = new_val[31:TVEC_BASE_LSB];
                    if (TABLE_CTRL_PRESENT) begin
                        st_nxt.tvec_mode = TVEC_MODE_TABLE;
                    end else if (new_val[1:0] == TVEC_MODE_DIRECT ||
                                 new_val[1:0] == TVEC_MODE_VECTORED) begin
                        st_nxt.tvec_mode = new_val[1:0];
                    end
                    // other codes leave the mode untouched
                end
                ADDR_VECTOR_TABLE: begin
                    st_nxt.vtab = new_val & VTAB_MASK;
                end
                default: begin
                    st_nxt.vtab = st_r.vtab;
                end
            endcase
        end

        // enables gate the interrupt lines of the same index
        st_nxt.irq_gated = TABLE_CTRL_PRESENT ? ZERO_WORD :
            (IRQ_LINES_IN & st_r.irq_enable & IRQ_ENABLE_WRITABLE);

        if (TRAP_IN) begin
            st_nxt.handler_valid = 1'b1;
            if (TRAP_IS_NMI_IN) begin
                st_nxt.handler =
                    {st_r.tvec_base, NMI_ENTRY, ENTRY_BYTE_BITS};
            end else if (TRAP_IS_IRQ_IN &&
                         st_r.tvec_mode == TVEC_MODE_VECTORED) begin
                st_nxt.handler = tvec_word + entry_off;
            end else if (TRAP_IS_IRQ_IN && TABLE_CTRL_PRESENT) begin
                // entry address in the table; base low bits are masked to alignment, so OR adds the offset
                st_nxt.handler = (st_r.vtab & VTAB_MASK) | entry_off;
            end else begin
                st_nxt.handler = tvec_word;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            st_r.boot          <= 1'b1;
            st_r.irq_enable    <= IRQ_ENABLE_RESET;
            st_r.tvec_base     <= '0;
            st_r.tvec_mode     <= TVEC_MODE_RESET;
            st_r.vtab          <= VTAB_RESET;
            st_r.rdata         <= ZERO_WORD;
            st_r.rvalid        <= 1'b0;
            st_r.unmapped      <= 1'b0;
            st_r.irq_gated     <= ZERO_WORD;
            st_r.handler       <= ZERO_WORD;
            st_r.handler_valid <= 1'b0;
        end else if (CLK_EN_IN) begin
            st_r <= st_nxt;
        end
    end

    assign CSR_RDATA_OUT     = st_r.rdata;
    assign CSR_RVALID_OUT    = st_r.rvalid;
    assign CSR_UNMAPPED_OUT  = st_r.unmapped;
    assign IRQ_GATED_OUT     = st_r.irq_gated;
    assign HANDLER_ADDR_OUT  = st_r.handler;
    assign HANDLER_VALID_OUT = st_r.handler_valid;

endmodule // mts_trap_setup

// ---- core/mts_pkg.sv ----
package mts_pkg;

    // register addresses in the control/status space
    localparam logic [11:0] ADDR_ISA_CAPABILITY   = 12'h301;
    localparam logic [11:0] ADDR_IRQ_ENABLE       = 12'h304;
    localparam logic [11:0] ADDR_TRAP_VECTOR_BASE = 12'h305;
    localparam logic [11:0] ADDR_VECTOR_TABLE     = 12'h307;

    // capability register fields
    localparam int          NATIVE_WORD_LENGTH_LSB = 30;
    localparam logic [1:0]  NATIVE_WORD_LENGTH_32  = 2'h1;
    localparam int          CAP_BIT_COMPRESSED     = 2;
    localparam int          CAP_BIT_EMBEDDED_BASE  = 4;
    localparam int          CAP_BIT_INTEGER_BASE   = 8;
    localparam int          CAP_BIT_MULDIV         = 12;
    localparam int          CAP_BIT_USER_MODE      = 20;
    localparam int          CAP_BIT_NONSTANDARD    = 23;

    // interrupt enable fields in basic mode
    localparam logic [31:0] IRQ_ENABLE_FAST_MASK   = 32'hffff_0000;
    localparam int          EXTERNAL_IRQ_ENABLE    = 11;
    localparam int          TIMER_IRQ_ENABLE       = 7;
    localparam int          SOFTWARE_IRQ_ENABLE    = 3;
    localparam logic [31:0] IRQ_ENABLE_RESET       = 32'h0000_0000;

    // trap vector base fields
    localparam int          TVEC_BASE_LSB          = 7;
    localparam int          TVEC_BASE_W            = 25;
    localparam logic [1:0]  TVEC_MODE_DIRECT       = 2'h0;
    localparam logic [1:0]  TVEC_MODE_VECTORED     = 2'h1;
    localparam logic [1:0]  TVEC_MODE_TABLE        = 2'h3;
    localparam logic [4:0]  TVEC_ZERO_FIELD        = 5'h00;
    localparam logic [4:0]  NMI_ENTRY              = 5'h0f;
    localparam logic [1:0]  ENTRY_BYTE_BITS        = 2'h0;
    localparam int          ENTRY_SHIFT            = 2;

    // vector table base
    localparam int          VTAB_MIN_ALIGN_BITS    = 6;
    localparam logic [31:0] VTAB_RESET             = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD              = 32'h0000_0000;

    typedef enum logic [1:0] {
        MTS_OP_NONE,
        MTS_OP_WRITE,
        MTS_OP_SET,
        MTS_OP_CLEAR
    } mts_op_e;

    typedef enum logic [1:0] {
        MTS_BASE_INTEGER,
        MTS_BASE_EMBEDDED
    } mts_base_e;

    // all state of the block
    typedef struct packed {
        logic                   boot;
        logic [31:0]            irq_enable;
        logic [TVEC_BASE_W-1:0] tvec_base;
        logic [1:0]             tvec_mode;
        logic [31:0]            vtab;
        logic [31:0]            rdata;
        logic                   rvalid;
        logic                   unmapped;
        logic [31:0]            irq_gated;
        logic [31:0]            handler;
        logic                   handler_valid;
    } mts_state_s;

endpackage

// ---- testbench/mts_trap_setup_assertions.sv ----
`timescale 1ns/1ps
module mts_trap_setup_assertions
    import mts_pkg::*;
#(
    parameter bit        TABLE_CTRL_PRESENT = 1'b0,
    parameter mts_base_e BASE_SET_OPTION    = MTS_BASE_INTEGER,
    parameter bit        MULDIV_OPTION      = 1'b1,
    parameter int        IRQ_ID_WIDTH       = 8
) (
    input wire logic                    REF_CLK_IN,
    input wire logic                    RSTN_IN,
    input wire logic                    CLK_EN_IN,
    input wire mts_op_e                 CSR_OP_IN,
    input wire logic [11:0]             CSR_ADDR_IN,
    input wire logic [31:0]             CSR_WDATA_IN,
    input wire logic [31:0]             TVEC_RESET_ADDR_IN,
    input wire logic [31:0]             IRQ_LINES_IN,
    input wire logic                    TRAP_IN,
    input wire logic                    TRAP_IS_IRQ_IN,
    input wire logic                    TRAP_IS_NMI_IN,
    input wire logic [IRQ_ID_WIDTH-1:0] TRAP_ID_IN,
    input wire logic [31:0]             CSR_RDATA_OUT,
    input wire logic                    CSR_RVALID_OUT,
    input wire logic                    CSR_UNMAPPED_OUT,
    input wire logic [31:0]             IRQ_GATED_OUT,
    input wire logic [31:0]             HANDLER_ADDR_OUT,
    input wire logic                    HANDLER_VALID_OUT
);
    localparam int          VN = (IRQ_ID_WIDTH + 2 > 6) ? IRQ_ID_WIDTH + 2 : 6;
    localparam logic [31:0] VMASK = (32'h1 << VN) - 32'h1;
    // table mode has no enable bits at all
    localparam logic [31:0] ZMASK = TABLE_CTRL_PRESENT ? 32'hffff_ffff
                                                       : 32'h0000_f777;
    logic acc;
    assign acc = CLK_EN_IN && (CSR_OP_IN != MTS_OP_NONE);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    AST_CAP_FIXED: assert property (acc && CSR_ADDR_IN == 12'h301 |=>
        (CSR_RDATA_OUT & ~32'h0000_1110) == 32'h4090_0004)
        else $error("capability fixed bits wrong");
    AST_CAP_BASE: assert property (acc && CSR_ADDR_IN == 12'h301 |=>
        CSR_RDATA_OUT[8] == (BASE_SET_OPTION == MTS_BASE_INTEGER) &&
        CSR_RDATA_OUT[4] == (BASE_SET_OPTION == MTS_BASE_EMBEDDED))
        else $error("capability base bits wrong");
    AST_CAP_MULDIV: assert property (acc && CSR_ADDR_IN == 12'h301 |=>
        CSR_RDATA_OUT[12] == MULDIV_OPTION)
        else $error("capability multiply bit wrong");
    AST_GATE_LINES: assert property (CLK_EN_IN |=>
        (IRQ_GATED_OUT & ~$past(IRQ_LINES_IN)) == 32'h0)
        else $error("gated line without its input");
    AST_GATE_ZERO: assert property ((IRQ_GATED_OUT & ZMASK) == 32'h0)
        else $error("gated output on reserved bit");
    AST_IRQEN_READ: assert property (acc && CSR_ADDR_IN == 12'h304 |=>
        (CSR_RDATA_OUT & ZMASK) == 32'h0)
        else $error("enable register reserved bit set");
    AST_TVEC_READ: assert property (acc && CSR_ADDR_IN == 12'h305 |=>
        CSR_RDATA_OUT[6:2] == 5'h00 && (TABLE_CTRL_PRESENT ?
        CSR_RDATA_OUT[1:0] == 2'h3 : !CSR_RDATA_OUT[1]))
        else $error("trap base low bits wrong");
    AST_VTAB_READ: assert property (acc && CSR_ADDR_IN == 12'h307 |=>
        (TABLE_CTRL_PRESENT ? (CSR_RDATA_OUT & VMASK) == 32'h0
        : CSR_UNMAPPED_OUT && CSR_RDATA_OUT == 32'h0))
        else $error("table base read wrong");
    AST_NMI_ADDR: assert property (CLK_EN_IN && TRAP_IN && TRAP_IS_NMI_IN |=>
        HANDLER_VALID_OUT && HANDLER_ADDR_OUT[6:0] == 7'h3c)
        else $error("nmi handler entry wrong");
    AST_EXC_ADDR: assert property (CLK_EN_IN && TRAP_IN && !TRAP_IS_NMI_IN
        && !TRAP_IS_IRQ_IN |=> HANDLER_VALID_OUT &&
        HANDLER_ADDR_OUT[6:0] == 7'h00)
        else $error("exception handler not at base");
endmodule // mts_trap_setup_assertions

bind mts_trap_setup mts_trap_setup_assertions #(
    .TABLE_CTRL_PRESENT(TABLE_CTRL_PRESENT), .BASE_SET_OPTION(BASE_SET_OPTION),
    .MULDIV_OPTION(MULDIV_OPTION), .IRQ_ID_WIDTH(IRQ_ID_WIDTH)
) u_chk (.*);

// ---- testbench/tb_machine_trap_setup_csrs.sv ----
`timescale 1ns/1ps
module tb_machine_trap_setup_csrs
    import mts_pkg::*;
;
    localparam logic [31:0] CAP = 32'h4090_1104;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        trap = 1'b0;
    logic        nmi = 1'b0;
    logic        irq = 1'b0;
    logic        en = 1'b1;
    mts_op_e     op = MTS_OP_NONE;
    logic [11:0] addr = 12'h000;
    logic [31:0] wd = 32'h0, lines = 32'h0;
    logic [7:0]  id = 8'h00;
    logic [31:0] rd_b, rd_t, ha_b, ha_t, gt_b, gt_t;
    logic        rv_b, rv_t, um_b, um_t, hv_b, hv_t;
    int          miscompares = 0, tests_run = 0, cycles = 0;

    mts_trap_setup u_dut (.REF_CLK_IN(ref_clk), .RSTN_IN(rstn),
        .CLK_EN_IN(en), .CSR_OP_IN(op), .CSR_ADDR_IN(addr),
        .CSR_WDATA_IN(wd), .TVEC_RESET_ADDR_IN(32'h8000_1fff),
        .IRQ_LINES_IN(lines), .TRAP_IN(trap), .TRAP_IS_IRQ_IN(irq),
        .TRAP_IS_NMI_IN(nmi), .TRAP_ID_IN(id), .CSR_RDATA_OUT(rd_b),
        .CSR_RVALID_OUT(rv_b), .CSR_UNMAPPED_OUT(um_b), .IRQ_GATED_OUT(gt_b),
        .HANDLER_ADDR_OUT(ha_b), .HANDLER_VALID_OUT(hv_b));
    // same stimulus into a table-controller build, each answer checked against its own expected value
    mts_trap_setup #(.TABLE_CTRL_PRESENT(1'b1)) u_tab (.REF_CLK_IN(ref_clk),
        .RSTN_IN(rstn), .CLK_EN_IN(en), .CSR_OP_IN(op), .CSR_ADDR_IN(addr),
        .CSR_WDATA_IN(wd), .TVEC_RESET_ADDR_IN(32'h8000_1fff),
        .IRQ_LINES_IN(lines), .TRAP_IN(trap), .TRAP_IS_IRQ_IN(irq),
        .TRAP_IS_NMI_IN(nmi), .TRAP_ID_IN(id), .CSR_RDATA_OUT(rd_t),
        .CSR_RVALID_OUT(rv_t), .CSR_UNMAPPED_OUT(um_t), .IRQ_GATED_OUT(gt_t),
        .HANDLER_ADDR_OUT(ha_t), .HANDLER_VALID_OUT(hv_t));

    initial forever #10 ref_clk = ~ref_clk;

    task report_and_stop;
        if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // set with zero operand doubles as a plain read
    task acc(input mts_op_e o, input logic [11:0] a,
             input logic [31:0] w, input logic [31:0] eb, input logic [31:0] et);
        @(posedge ref_clk);
        op <= o;
        addr <= a;
        wd <= w;
        @(posedge ref_clk);
        op <= MTS_OP_NONE;
        #1;
        chk(32'(rv_b & rv_t), 32'h1);
        chk(rd_b, eb);
        chk(rd_t, et);
    endtask

    task trp(input logic n, input logic i, input logic [7:0] d,
             input logic [31:0] eb, input logic [31:0] et);
        @(posedge ref_clk);
        trap <= 1'b1;
        nmi <= n;
        irq <= i;
        id <= d;
        @(posedge ref_clk);
        trap <= 1'b0;
        #1;
        chk(32'(hv_b & hv_t), 32'h1);
        chk(ha_b, eb);
        chk(ha_t, et);
    endtask

    task t_reset;
        acc(MTS_OP_SET, 12'h304, 32'h0, 32'h0, 32'h0);
        acc(MTS_OP_SET, 12'h305, 32'h0, 32'h8000_1f81, 32'h8000_1f83);
        acc(MTS_OP_SET, 12'h307, 32'h0, 32'h0, 32'h0);
    endtask

    task t_cap;
        acc(MTS_OP_WRITE, 12'h301, 32'hffff_ffff, CAP, CAP);
        acc(MTS_OP_CLEAR, 12'h301, 32'hffff_ffff, CAP, CAP);
        acc(MTS_OP_SET, 12'h301, 32'h0, CAP, CAP);
    endtask

    task t_irq_en;
        acc(MTS_OP_WRITE, 12'h304, 32'hffff_ffff, 32'h0, 32'h0);
        acc(MTS_OP_SET, 12'h304, 32'h0, 32'hffff_0888, 32'h0);
        acc(MTS_OP_CLEAR, 12'h304, 32'h800, 32'hffff_0888, 32'h0);
        acc(MTS_OP_SET, 12'h304, 32'h0, 32'hffff_0088, 32'h0);
        @(posedge ref_clk);
        lines <= 32'hffff_ffff;
        @(posedge ref_clk);
        #1;
        chk(gt_b, 32'hffff_0088);
        chk(gt_t, 32'h0);
    endtask

    // a write offered while the enable is low must be lost entirely
    task t_freeze;
        @(posedge ref_clk);
        en <= 1'b0;
        op <= MTS_OP_WRITE;
        addr <= 12'h304;
        wd <= 32'h0;
        @(posedge ref_clk);
        en <= 1'b1;
        op <= MTS_OP_NONE;
        #1;
        chk(32'(rv_b | rv_t), 32'h0);
        acc(MTS_OP_SET, 12'h304, 32'h0, 32'hffff_0088, 32'h0);
    endtask

    task t_tvec;
        // mode code 2 is illegal in basic mode: old mode must survive
        acc(MTS_OP_WRITE, 12'h305, 32'h1234_56fe, 32'h8000_1f81, 32'h8000_1f83);
        acc(MTS_OP_SET, 12'h305, 32'h0, 32'h1234_5681, 32'h1234_5683);
        acc(MTS_OP_CLEAR, 12'h305, 32'h1, 32'h1234_5681, 32'h1234_5683);
        acc(MTS_OP_SET, 12'h305, 32'h0, 32'h1234_5680, 32'h1234_5683);
        acc(MTS_OP_SET, 12'h305, 32'h1, 32'h1234_5680, 32'h1234_5683);
    endtask

    task t_vtab;
        // table placed on a 1024-byte boundary, as software must
        acc(MTS_OP_WRITE, 12'h307, 32'hffff_fc00, 32'h0, 32'h0);
        acc(MTS_OP_WRITE, 12'h307, 32'hffff_ffff, 32'h0, 32'hffff_fc00);
        acc(MTS_OP_SET, 12'h307, 32'h0, 32'h0, 32'hffff_fc00);
        chk(32'(um_b), 32'h1);
        chk(32'(um_t), 32'h0);
    endtask

    task t_trap;
        trp(1'b1, 1'b0, 8'h00, 32'h1234_56bc, 32'h1234_56bc);
        trp(1'b0, 1'b0, 8'h05, 32'h1234_5680, 32'h1234_5680);
        trp(1'b0, 1'b1, 8'h05, 32'h1234_5694, 32'hffff_fc14);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_cap();
        t_irq_en();
        t_freeze();
        t_tvec();
        t_vtab();
        t_trap();
        report_and_stop();
    end
endmodule // tb_machine_trap_setup_csrs
